/* File: core/tws_top.v */
// Two-wire port with firmware master support, reached over AHB-Lite.
// Assumes one 20 MHz clock, external pull-ups on both lines, single word accesses.
// How it works
// R1: Start and stop flags clear on reset and while the port is disabled.
// R2: Start and stop flags follow the latest condition seen on the bus.
// R3: Firmware may take the bus when stop is set or both flags clear.
// R4: A line whose direction bit is output is driven low, latch ignored.
// R5: Firmware sends one by releasing data, zero by making it output.
// R6: Firmware drives the clock line likewise through its direction bit.
// R7: Port flag sets on START, STOP and each completed byte; START/STOP only in modes 1011, 1110, 1111, slave bytes only if addressed.
// R8: Mode 1011 gives START/STOP interrupts, slave idle; master works beside slaves.
// R9: Firmware sorts out which cause raised the shared port flag.
// R10: Enabling the interrupt during a busy bus fires at the next STOP.
// R11: On lost arbitration firmware releases both lines via direction bits.
// R12: Arbitration lost in data stage means firmware retransmits later.
// R13: Slave keeps receiving after lost arbitration and acknowledges its address.
// R14: Firmware keeps sample-phase and edge-select bits clear in two-wire mode.
// R15: Enabled two-wire mode makes both pins open drain when set as inputs.
// R16: START is data falling with clock high; STOP is data rising.
`timescale 1ns/10ps
`include "tws_map.vh"
module tws_top (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg [31:0] hrdata,
   output reg hresp,
   input wire scl_in,
   output reg scl_out,
   output reg scl_oe,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   output reg irq
);
   // Register file
   reg [7:0] interrupt_control;
   reg [7:0] peripheral_irq_flags;
   reg [7:0] serial_buffer;
   reg [7:0] serial_control;
   reg [7:0] pin_output_latch_direction;
   reg [7:0] peripheral_irq_enables;
   reg [7:0] slave_address;
   reg [7:0] pin_output_latch;
   reg [2:0] evt_status;
   reg [2:0] evt_enable;
   // Status fields
   reg [1:0] phase_bits;
   reg data_addr_flag;
   reg stop_flag;
   reg start_flag;
   reg rw_flag;
   reg buffer_full_flag;
   // Receive engine
   reg [7:0] shift_reg;
   reg [3:0] bit_cnt;
   reg in_frame;
   reg first_byte;
   reg addressed;
   reg ack_drive;
   // Bus slave state
   reg pend;
   reg pend_write;
   reg [7:0] pend_idx;

   wire scl_s;
   wire sda_s;
   wire scl_rise;
   wire scl_fall;
   wire start_seen;
   wire stop_seen;

   tws_line_watch u_watch (
      .hclk(hclk),
      .hresetn(hresetn),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .scl_s(scl_s),
      .sda_s(sda_s),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_seen(start_seen),
      .stop_seen(stop_seen)
   );

   // Mode decode
   wire [3:0] port_mode_select = serial_control[3:0];
   wire port_enable_bit = serial_control[`TWS_CTL_EN];
   wire mode_is_i2c = (port_mode_select == `TWS_MODE_SLV7) ||
      (port_mode_select == `TWS_MODE_SLV10) ||
      (port_mode_select == `TWS_MODE_FW_MASTER) ||
      (port_mode_select == `TWS_MODE_SLV7_SS) ||
      (port_mode_select == `TWS_MODE_SLV10_SS);
   wire i2c_on = port_enable_bit & mode_is_i2c;
   wire ss_irq_mode = (port_mode_select == `TWS_MODE_FW_MASTER) ||
      (port_mode_select == `TWS_MODE_SLV7_SS) ||
      (port_mode_select == `TWS_MODE_SLV10_SS);
   wire slave_active = i2c_on & (port_mode_select != `TWS_MODE_FW_MASTER);

   // Byte end: falling clock edge after the eighth data bit
   wire byte_end = i2c_on & in_frame & scl_fall & (bit_cnt == 4'h8);
   wire addr_match = slave_active & first_byte & (shift_reg[7:1] == slave_address[7:1]);
   wire take_byte = addr_match | (addressed & ~first_byte);
   wire rx_ok = ~buffer_full_flag & ~serial_control[`TWS_CTL_OVF];
   // Master mode counts every byte; slave modes count only bytes meant for us
   wire byte_evt = byte_end & (~slave_active | take_byte); // R7
   wire start_evt = i2c_on & ss_irq_mode & start_seen; // R8
   wire stop_evt = i2c_on & ss_irq_mode & stop_seen; // R8 R10
   wire [2:0] evt_set = {byte_evt, stop_evt, start_evt};

   // Bus access decode
   wire ahb_go = hsel & hready & htrans[1];
   wire wr = pend & pend_write;
   wire rd_buf = pend & ~pend_write & (pend_idx == `TWS_IDX_BUFFER);
   wire [7:0] wbyte = hwdata[7:0];

   // AHB-Lite slave: one wait state, so read data comes from a flop
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend <= 1'b0;
         pend_write <= 1'b0;
         pend_idx <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
         if (pend) begin
            pend <= 1'b0;
            hreadyout <= 1'b1;
         end else if (ahb_go) begin
            pend <= 1'b1;
            pend_write <= hwrite;
            pend_idx <= haddr[9:2];
            hreadyout <= 1'b0;
         end
      end
   end

   // Read mux; unmapped and write-only locations read as zero
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (pend & ~pend_write) begin
         case (pend_idx)
            `TWS_IDX_INT_CTRL: hrdata <= {24'h000000, interrupt_control};
            `TWS_IDX_IRQ_FLAGS: hrdata <= {24'h000000, peripheral_irq_flags};
            `TWS_IDX_BUFFER: hrdata <= {24'h000000, serial_buffer};
            `TWS_IDX_CONTROL: hrdata <= {24'h000000, serial_control};
            `TWS_IDX_DIRECTION: hrdata <= {24'h000000, pin_output_latch_direction};
            `TWS_IDX_IRQ_ENABLES: hrdata <= {24'h000000, peripheral_irq_enables};
            `TWS_IDX_SLAVE_ADDR: hrdata <= {24'h000000, slave_address};
            `TWS_IDX_STATUS: hrdata <= {24'h000000, phase_bits, data_addr_flag,
               stop_flag, start_flag, rw_flag, 1'b0, buffer_full_flag};
            `TWS_IDX_EVT_STATUS: hrdata <= {29'h0000000, evt_status};
            `TWS_IDX_EVT_ENABLE: hrdata <= {29'h0000000, evt_enable};
            `TWS_IDX_PIN_LATCH: hrdata <= {24'h000000, pin_output_latch};
            default: hrdata <= 32'h00000000;
         endcase
      end
   end

   // Plain software registers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         interrupt_control <= `TWS_RST_ZERO;
         pin_output_latch_direction <= `TWS_RST_DIRECTION;
         peripheral_irq_enables <= `TWS_RST_ZERO;
         slave_address <= `TWS_RST_ZERO;
         pin_output_latch <= `TWS_RST_ZERO;
         evt_enable <= 3'h0;
         phase_bits <= 2'h0;
      end else if (wr) begin
         case (pend_idx)
            `TWS_IDX_INT_CTRL: interrupt_control <= wbyte;
            `TWS_IDX_DIRECTION: pin_output_latch_direction <= wbyte;
            `TWS_IDX_IRQ_ENABLES: peripheral_irq_enables <= wbyte;
            `TWS_IDX_SLAVE_ADDR: slave_address <= wbyte;
            `TWS_IDX_PIN_LATCH: pin_output_latch <= wbyte;
            `TWS_IDX_EVT_ENABLE: evt_enable <= wbyte[2:0];
            `TWS_IDX_STATUS: phase_bits <= wbyte[7:6]; // R14
            default: ;
         endcase
      end
   end

   // Sticky event status; a new event wins over a clear in the same cycle
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         evt_status <= 3'h0;
      end else if (wr && pend_idx == `TWS_IDX_EVT_CLEAR) begin
         evt_status <= (evt_status & ~wbyte[2:0]) | evt_set;
      end else begin
         evt_status <= evt_status | evt_set;
      end
   end

   // Shared port flag; software writes it, hardware set wins
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         peripheral_irq_flags <= `TWS_RST_ZERO;
      end else if (wr && pend_idx == `TWS_IDX_IRQ_FLAGS) begin
         peripheral_irq_flags <= wbyte;
         if (|evt_set)
            peripheral_irq_flags[`TWS_IRQ_FLAG_BIT] <= 1'b1; // R7
      end else if (|evt_set) begin
         peripheral_irq_flags[`TWS_IRQ_FLAG_BIT] <= 1'b1; // R7
      end
   end

   // Control register; overflow is also set by hardware
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         serial_control <= `TWS_RST_ZERO;
      end else begin
         if (wr && pend_idx == `TWS_IDX_CONTROL)
            serial_control <= wbyte;
         if (byte_end & take_byte & ~rx_ok)
            serial_control[`TWS_CTL_OVF] <= 1'b1;
      end
   end

   // Start and stop flags track the latest bus condition
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         start_flag <= 1'b0; // R1
         stop_flag <= 1'b0; // R1
      end else if (!i2c_on) begin
         start_flag <= 1'b0; // R1
         stop_flag <= 1'b0; // R1
      end else if (start_seen) begin
         start_flag <= 1'b1; // R2
         stop_flag <= 1'b0; // R2 R3
      end else if (stop_seen) begin
         start_flag <= 1'b0; // R2
         stop_flag <= 1'b1; // R2 R3
      end
   end

   // Receive engine: shifts on rising clock, acts on falling clock
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shift_reg <= 8'h00;
         bit_cnt <= 4'h0;
         in_frame <= 1'b0;
         first_byte <= 1'b0;
         addressed <= 1'b0;
         ack_drive <= 1'b0;
      end else if (!i2c_on || stop_seen) begin
         in_frame <= 1'b0;
         addressed <= 1'b0;
         ack_drive <= 1'b0;
         bit_cnt <= 4'h0;
      end else if (start_seen) begin
         in_frame <= 1'b1;
         first_byte <= 1'b1;
         addressed <= 1'b0;
         ack_drive <= 1'b0;
         bit_cnt <= 4'h0;
      end else if (in_frame) begin
         if (scl_rise && bit_cnt < 4'h8) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
         end else if (scl_fall && bit_cnt == 4'h8) begin
            // Keeps receiving even after our own master lost arbitration
            if (first_byte)
               addressed <= addr_match; // R13
            ack_drive <= take_byte & rx_ok; // R13
            first_byte <= 1'b0;
            bit_cnt <= 4'h9;
         end else if (scl_fall && bit_cnt == 4'h9) begin
            ack_drive <= 1'b0;
            bit_cnt <= 4'h0;
         end
      end
   end

   // Buffer and byte status
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         serial_buffer <= 8'h00;
         buffer_full_flag <= 1'b0;
         rw_flag <= 1'b0;
         data_addr_flag <= 1'b0;
      end else if (!i2c_on) begin
         buffer_full_flag <= 1'b0;
         rw_flag <= 1'b0;
         data_addr_flag <= 1'b0;
      end else if (byte_end & take_byte & rx_ok) begin
         serial_buffer <= shift_reg;
         buffer_full_flag <= 1'b1;
         data_addr_flag <= ~first_byte;
         if (first_byte)
            rw_flag <= shift_reg[0];
      end else if (wr && pend_idx == `TWS_IDX_BUFFER) begin
         serial_buffer <= wbyte;
      end else if (rd_buf) begin
         // Reading the buffer empties it
         buffer_full_flag <= 1'b0;
      end
   end

   // Pin drivers: in two-wire mode an output pin only ever pulls low
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_out <= 1'b0;
         scl_oe <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
      end else if (i2c_on) begin
         scl_out <= 1'b0; // R4 R15
         scl_oe <= ~pin_output_latch_direction[`TWS_PIN_SCL]; // R4 R15
         sda_out <= 1'b0; // R4 R15
         sda_oe <= ~pin_output_latch_direction[`TWS_PIN_SDA] | ack_drive; // R4 R13 R15
      end else begin
         // Plain port pins when the two-wire function is off
         scl_out <= pin_output_latch[`TWS_PIN_SCL];
         scl_oe <= ~pin_output_latch_direction[`TWS_PIN_SCL];
         sda_out <= pin_output_latch[`TWS_PIN_SDA];
         sda_oe <= ~pin_output_latch_direction[`TWS_PIN_SDA];
      end
   end

   // Level interrupt while an enabled event bit is set
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         irq <= 1'b0;
      else
         irq <= |(evt_status & evt_enable); // R10
   end
endmodule // tws_top

/* File: pkg/tws_map.vh */
// Register indices, field positions and reset values of the two-wire port.
// Assumes a 32-bit AHB-Lite slave: byte address is four times the index.
`ifndef TWS_MAP_VH
`define TWS_MAP_VH

// Register indices (byte address = index * 4)
`define TWS_IDX_INT_CTRL 8'h0B
`define TWS_IDX_IRQ_FLAGS 8'h0C
`define TWS_IDX_BUFFER 8'h13
`define TWS_IDX_CONTROL 8'h14
`define TWS_IDX_DIRECTION 8'h86
`define TWS_IDX_IRQ_ENABLES 8'h8C
`define TWS_IDX_SLAVE_ADDR 8'h93
`define TWS_IDX_STATUS 8'h94
`define TWS_IDX_EVT_STATUS 8'hA0
`define TWS_IDX_EVT_CLEAR 8'hA1
`define TWS_IDX_EVT_ENABLE 8'hA2
`define TWS_IDX_PIN_LATCH 8'hA3

// Reset values
`define TWS_RST_DIRECTION 8'hFF
`define TWS_RST_ZERO 8'h00

// Field positions
`define TWS_IRQ_FLAG_BIT 3
`define TWS_CTL_WRITE_COLLISION_FLAG 7
`define TWS_CTL_OVF 6
`define TWS_CTL_EN 5
`define TWS_CTL_CKP 4
`define TWS_ST_DA 5
`define TWS_ST_STOP 4
`define TWS_ST_START 3
`define TWS_ST_RW 2
`define TWS_ST_BF 0
`define TWS_PIN_SCL 4
`define TWS_PIN_SDA 1

// Event status bit positions
`define TWS_EV_START 0
`define TWS_EV_STOP 1
`define TWS_EV_BYTE 2

// Mode codes of the four mode-select bits
`define TWS_MODE_SLV7 4'h6
`define TWS_MODE_SLV10 4'h7
`define TWS_MODE_FW_MASTER 4'hB
`define TWS_MODE_SLV7_SS 4'hE
`define TWS_MODE_SLV10_SS 4'hF

`endif

/* File: core/tws_line_watch.v */
// Line watcher: synchronises the clock and data pins and finds bus events.
// Assumes scl_in and sda_in are asynchronous pin levels with pull-ups.
`timescale 1ns/10ps
module tws_line_watch (
   input wire hclk,
   input wire hresetn,
   input wire scl_in,
   input wire sda_in,
   output reg scl_s,
   output reg sda_s,
   output wire scl_rise,
   output wire scl_fall,
   output wire start_seen,
   output wire stop_seen
);
   reg scl_m;
   reg sda_m;
   reg scl_d;
   reg sda_d;

   // Two-stage synchronisers, then one delay stage for edge finding
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_m <= 1'b1;
         sda_m <= 1'b1;
         scl_s <= 1'b1;
         sda_s <= 1'b1;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_m <= scl_in;
         sda_m <= sda_in;
         scl_s <= scl_m;
         sda_s <= sda_m;
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // Edges of the clock line
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   // Data moving while the clock stays high marks START or STOP
   assign start_seen = scl_s & scl_d & sda_d & ~sda_s; // R16
   assign stop_seen = scl_s & scl_d & ~sda_d & sda_s; // R16
endmodule // tws_line_watch

/* File: bench/tws_top_sva.sv */
// Checker for tws_top: AHB answers, pin drive and the event interrupt.
// Assumes it is bound to tws_top; it shadows registers from the writes it sees.
`timescale 1ns/10ps
`include "tws_map.vh"
module tws_top_sva (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire scl_in,
   input wire scl_out,
   input wire scl_oe,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe,
   input wire irq
);
   logic ph_wr;
   logic [7:0] ph_idx, dir_sh, ctl_sh, en_sh;
   wire tw_on = ctl_sh[5] && (ctl_sh[3:0] inside {4'h6, 4'h7, 4'hB, 4'hE, 4'hF});
   wire fw_ev = ctl_sh[5] && (ctl_sh[3:0] inside {4'hB, 4'hE, 4'hF});
   // Shadows lag the design by a cycle, so checks wait until they are stable
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr <= 1'b0;
         ph_idx <= 8'h00;
         dir_sh <= 8'hFF;
         ctl_sh <= 8'h00;
         en_sh <= 8'h00;
      end else begin
         if (hready) begin
            ph_wr <= hsel && htrans[1] && hwrite;
            ph_idx <= haddr[9:2];
         end
         if (ph_wr && hready) begin
            case (ph_idx)
               `TWS_IDX_DIRECTION: dir_sh <= hwdata[7:0];
               `TWS_IDX_CONTROL: ctl_sh <= hwdata[7:0];
               `TWS_IDX_EVT_ENABLE: en_sh <= hwdata[7:0];
               default: ;
            endcase
         end
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property ev_irq(logic edge_ok, logic en);
      fw_ev && en && scl_in && $past(scl_in) && edge_ok |-> ##[1:10] irq;
   endproperty
   ahb_wait_a: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
      else $error("no single wait state");
   ahb_okay_a: assert property (!hresp)
      else $error("response not OKAY");
   scl_drive_a: assert property (
      tw_on && $stable(dir_sh) && $stable(ctl_sh) |-> scl_oe == !dir_sh[4] && !scl_out)
      else $error("clock pin drive wrong");
   sda_drive_a: assert property (
      tw_on && $stable(dir_sh) && $stable(ctl_sh) |-> !sda_out && (dir_sh[1] || sda_oe))
      else $error("data pin drive wrong");
   start_irq_a: assert property (ev_irq($fell(sda_in), en_sh[0]))
      else $error("START gave no interrupt");
   stop_irq_a: assert property (ev_irq($rose(sda_in), en_sh[1]))
      else $error("STOP gave no interrupt");
   slave_quiet_a: assert property (
      tw_on && ctl_sh[3:0] inside {4'h6, 4'h7} && en_sh == 8'h01 && !irq && scl_in
      && $fell(sda_in) |-> !irq [*8])
      else $error("slave setting raised START interrupt");
   irq_mask_a: assert property ($past(en_sh) == 8'h00 && en_sh == 8'h00 |-> !irq)
      else $error("interrupt with enables clear");
   cover property (fw_ev && scl_in && $fell(sda_in));
   cover property (sda_oe && dir_sh[1]);
   cover property ($rose(irq));
endmodule // tws_top_sva

/* File: bench/tws_bus_peer.sv */
// Second bus party: a master framing START, bytes and STOP on the wire.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/10ps
module tws_bus_peer (
   input wire scl,
   input wire sda,
   output logic scl_dn = 1'b0,
   output logic sda_dn = 1'b0
);
   // Takes the bus only from idle, then holds the clock low
   task start_c;
      // Step off the system clock edge so the far side never races the synchroniser
      #10;
      wait (scl && sda);
      sda_dn = 1'b1;
      #200;
      scl_dn = 1'b1;
      #200;
   endtask
   // One 400 ns bit: data set while clock low, read at mid high
   task bit_c(input logic b, output logic s);
      sda_dn = !b;
      #100;
      scl_dn = 1'b0;
      #100;
      s = sda;
      #100;
      scl_dn = 1'b1;
      #100;
   endtask
   // Ninth bit is released so the addressed slave may pull it low
   task byte_c(input logic [7:0] v, output logic ack);
      logic s;
      #10;
      for (int i = 7; i >= 0; i--) begin
         bit_c(v[i], s);
      end
      bit_c(1'b1, ack);
   endtask
   // Data rises while the clock is high, then the lines stand released
   task stop_c;
      sda_dn = 1'b1;
      #100;
      scl_dn = 1'b0;
      #100;
      sda_dn = 1'b0;
      #400;
   endtask
endmodule // tws_bus_peer

/* File: bench/testbench.sv */
// Testbench: tws_top over AHB-Lite, with a second master on the wire.
// Assumes pull-ups on both lines, modelled by the wired-AND below.
`timescale 1ns/10ps
`include "tws_map.vh"
module testbench;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   wire hreadyout, hresp, scl_out, scl_oe, sda_out, sda_oe, irq, scl_dn, sda_dn;
   wire [31:0] hrdata;
   // Released line reads high
   wire scl = (scl_oe ? scl_out : 1'b1) && !scl_dn;
   wire sda = (sda_oe ? sda_out : 1'b1) && !sda_dn;
   int n_mismatch = 0, checks = 0, seed = 77439;
   logic [7:0] d;
   logic ack, fw;
   logic [3:0] md [5] = '{`TWS_MODE_FW_MASTER, `TWS_MODE_SLV7_SS, `TWS_MODE_SLV10_SS,
      `TWS_MODE_SLV7, `TWS_MODE_SLV10};
   logic [7:0] ri [6] = '{`TWS_IDX_DIRECTION, `TWS_IDX_CONTROL, `TWS_IDX_STATUS,
      `TWS_IDX_IRQ_FLAGS, `TWS_IDX_SLAVE_ADDR, `TWS_IDX_IRQ_ENABLES};
   always #25 hclk = !hclk;
   tws_top u_tws_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .scl_in(scl), .scl_out,
      .scl_oe, .sda_in(sda), .sda_out, .sda_oe, .irq);
   tws_bus_peer u_tws_bus_peer (.scl, .sda, .scl_dn, .sda_dn);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Single transfer; hready and read data are taken at the rising edge, as the slave sees them
   task automatic xf(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {22'h0, idx, 2'b00};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input logic [7:0] m);
      xf(idx, 1'b0, 8'h00);
      chk(rd & {24'h0, m}, {24'h0, exp});
   endtask
   task print_verdict;
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // The tests need well under a millisecond
   initial begin
      #4000000;
      n_mismatch++;
      print_verdict;
   end
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (ri[i]) rdc(ri[i], i == 0 ? 8'hFF : 8'h00, 8'hFF);
      xf(8'h50, 1'b1, 8'h5A);
      rdc(8'h50, 8'h00, 8'hFF);
      $display("test reset done");
      xf(`TWS_IDX_STATUS, 1'b1, 8'h00);
      xf(`TWS_IDX_PIN_LATCH, 1'b1, 8'hFF);
      xf(`TWS_IDX_CONTROL, 1'b1, 8'h2B);
      xf(`TWS_IDX_EVT_ENABLE, 1'b1, 8'h01);
      // Latch holds ones, yet an output pin must go low
      for (int i = 0; i < 16; i++) begin
         d = 8'($random(seed));
         xf(`TWS_IDX_DIRECTION, 1'b1, d);
         repeat (2) @(posedge hclk);
         chk({28'h0, scl_oe, scl_out, sda_oe, sda_out}, {28'h0, !d[4], 1'b0, !d[1], 1'b0});
         chk({30'h0, scl, sda}, {30'h0, d[4], d[1]});
      end
      xf(`TWS_IDX_DIRECTION, 1'b1, 8'hFF);
      $display("test line drive done");
      xf(`TWS_IDX_SLAVE_ADDR, 1'b1, 8'hFF);
      // Interrupt enabled mid-frame must wait for STOP
      foreach (md[i]) begin
         fw = md[i] inside {`TWS_MODE_FW_MASTER, `TWS_MODE_SLV7_SS, `TWS_MODE_SLV10_SS};
         xf(`TWS_IDX_CONTROL, 1'b1, {4'h2, md[i]});
         xf(`TWS_IDX_EVT_ENABLE, 1'b1, fw ? 8'h00 : 8'h01);
         xf(`TWS_IDX_EVT_CLEAR, 1'b1, 8'h07);
         xf(`TWS_IDX_IRQ_FLAGS, 1'b1, 8'h00);
         u_tws_bus_peer.start_c;
         // Another master holds data low: firmware that expected high lets both lines go
         if (sda === 1'b0)
            xf(`TWS_IDX_DIRECTION, 1'b1, 8'hFF);
         chk({30'h0, scl_oe, sda_oe}, 32'h0);
         rdc(`TWS_IDX_STATUS, 8'h08, 8'h18);
         rdc(`TWS_IDX_EVT_STATUS, {7'h0, fw}, 8'hFF);
         xf(`TWS_IDX_EVT_CLEAR, 1'b1, 8'h07);
         xf(`TWS_IDX_EVT_ENABLE, 1'b1, 8'h03);
         chk({31'h0, irq}, 32'h0);
         u_tws_bus_peer.byte_c(8'($random(seed)) & 8'hFD, ack);
         u_tws_bus_peer.stop_c;
         chk({31'h0, irq}, {31'h0, fw});
         rdc(`TWS_IDX_STATUS, 8'h10, 8'h18);
         rdc(`TWS_IDX_IRQ_FLAGS, {4'h0, fw, 3'h0}, 8'h08);
         // Firmware retries its own transfer once the bus is free again
         xf(`TWS_IDX_DIRECTION, 1'b1, 8'hFD);
         repeat (4) @(posedge hclk);
         rdc(`TWS_IDX_STATUS, 8'h08, 8'h18);
         xf(`TWS_IDX_DIRECTION, 1'b1, 8'hFF);
         xf(`TWS_IDX_CONTROL, 1'b1, {4'h0, md[i]});
         rdc(`TWS_IDX_STATUS, 8'h00, 8'h18);
      end
      // Port disabled: output pins follow the latch and drive high
      xf(`TWS_IDX_DIRECTION, 1'b1, 8'hED);
      repeat (2) @(posedge hclk);
      chk({28'h0, scl_oe, scl_out, sda_oe, sda_out}, 32'hF);
      xf(`TWS_IDX_DIRECTION, 1'b1, 8'hFF);
      $display("test bus events done");
      xf(`TWS_IDX_CONTROL, 1'b1, 8'h26);
      xf(`TWS_IDX_EVT_CLEAR, 1'b1, 8'h07);
      xf(`TWS_IDX_EVT_ENABLE, 1'b1, 8'h04);
      // Second frame finds the buffer full: no acknowledge, flag still set
      for (int i = 0; i < 2; i++) begin
         u_tws_bus_peer.start_c;
         u_tws_bus_peer.byte_c(8'hFE, ack);
         u_tws_bus_peer.stop_c;
         chk({31'h0, ack}, i);
         chk({31'h0, irq}, 32'h1);
         xf(`TWS_IDX_EVT_ENABLE, 1'b1, 8'h00);
         // The interrupt flop follows the enable one cycle after the write
         @(posedge hclk);
         chk({31'h0, irq}, 32'h0);
         xf(`TWS_IDX_EVT_CLEAR, 1'b1, 8'h04);
         xf(`TWS_IDX_EVT_ENABLE, 1'b1, 8'h04);
      end
      rdc(`TWS_IDX_BUFFER, 8'hFE, 8'hFF);
      rdc(`TWS_IDX_CONTROL, 8'h66, 8'hFF);
      // Reset in mid-run must clear the stop flag left by the last frame
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(`TWS_IDX_STATUS, 8'h00, 8'hFF);
      $display("test slave address done");
      print_verdict;
   end
endmodule // testbench
bind tws_top tws_top_sva u_tws_top_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hreadyout, .hresp, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out,
   .sda_oe, .irq);
